/* rtl/sdsb_pkg.sv */
// Constants for the stepper driver status register bank.
// Assumes a byte-wide read port driven by the serial front end.
package sdsb_pkg;

    localparam int          SDSB_ADDR_W      = 7;
    localparam int          SDSB_DATA_W      = 8;
    localparam int          SDSB_POS_W       = 7;
    localparam logic [6:0]  SDSB_ADDR_SUPPLY = 7'h04;
    localparam logic [6:0]  SDSB_ADDR_XOC    = 7'h05;
    localparam logic [6:0]  SDSB_ADDR_YOC    = 7'h06;
    localparam logic [6:0]  SDSB_ADDR_POS    = 7'h07;
    localparam logic [7:0]  SDSB_RESET_VAL   = 8'h00;
    localparam int          SDSB_PARITY_POS  = 7;
    localparam int          SDSB_WARN_POS    = 6;
    localparam int          SDSB_PUMP_POS    = 5;
    localparam int          SDSB_OPEN_X_POS  = 3;
    localparam int          SDSB_OPEN_Y_POS  = 2;
    localparam int          SDSB_OC_LSB      = 3;
    localparam int          SDSB_SHUTDOWN_POS = 2;

endpackage : sdsb_pkg

/* rtl/sdsb_parity.sv */
// Even parity encoder: places a parity bit over seven data bits.
// Purely combinational; caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module sdsb_parity
    import sdsb_pkg::*;
(
    input  wire logic [6:0] data_in,
    output logic      [7:0] word_out
);
    // Parity makes total ones even
    assign word_out = {^data_in, data_in};
endmodule : sdsb_parity
`default_nettype wire

/* rtl/sdsb_status_bank.sv */
// Read-only diagnostic status bank of a bipolar stepper driver.
// Assumes live fault inputs synchronous to clk, and a one-cycle read
// strobe with address from the serial front end.
// Operation
// [RULE_01] Offset 05h: X overcurrent flags bits 6..3, parity bit 7, latched.
// [RULE_02] Offset 06h: Y overcurrent bits 6..3, shutdown bit 2, latched.
// [RULE_03] Offset 07h: parity and live seven-bit micro-step position.
// [RULE_04] Supply register: warning, pump, open coils; live, not latched.
// [RULE_05] Charge pump flag is 1 while pump voltage is too low.
// [RULE_06] Open coil flag is 1 while its winding is open.
// [RULE_07] One overcurrent flag per transistor, eight total, 1 on fault.
// [RULE_08] Reset clears all flags and position to zero.
// [RULE_09] Registers are read only; writes change nothing.
// [RULE_10] Bit 7 gives even parity over the whole register.
// [RULE_11] Latched flags hold after cause ends, clear after a read.
`timescale 1ns/1ps
`default_nettype none
module sdsb_status_bank
    import sdsb_pkg::*;
#(
    parameter int POS_W = SDSB_POS_W
)(
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             rd_strobe,
    input  wire logic [6:0]       rd_addr,
    input  wire logic             wr_strobe,
    input  wire logic [7:0]       wr_data,
    input  wire logic             thermal_warning_flag,
    input  wire logic             charge_pump_low,
    input  wire logic             open_coil_x_flag,
    input  wire logic             open_coil_y_flag,
    input  wire logic [3:0]       x_overcurrent,
    input  wire logic [3:0]       y_overcurrent,
    input  wire logic             thermal_shutdown_flag,
    input  wire logic [POS_W-1:0] translator_step_position,
    output logic      [7:0]       rd_data_ff,
    output logic                  rd_valid_ff
);

    ////////////////////////////////////////////////////////////////////
    // Live and latched state
    logic [6:0] supply_ff;
    logic [6:0] pos_ff;
    logic [3:0] xoc_ff;
    logic [4:0] yoc_ff;
    logic [3:0] nxt_xoc;
    logic [4:0] nxt_yoc;
    logic       rd_x;
    logic       rd_y;

    assign rd_x = rd_strobe && (rd_addr == SDSB_ADDR_XOC);
    assign rd_y = rd_strobe && (rd_addr == SDSB_ADDR_YOC);

    // Live snapshot; bits 4,1,0 read zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            supply_ff <= 7'h00; // RULE_08
            pos_ff    <= 7'h00; // RULE_08
        end else begin
            supply_ff <= {thermal_warning_flag, charge_pump_low, 1'b0,
                          open_coil_x_flag, open_coil_y_flag,
                          2'b00}; // RULE_04 RULE_05 RULE_06
            pos_ff    <= translator_step_position[6:0]; // RULE_03
        end
    end

    // Set wins over read-clear so no fault is lost
    always_comb begin
        nxt_xoc = (rd_x ? 4'h0 : xoc_ff) | x_overcurrent; // RULE_07 RULE_11
        nxt_yoc = (rd_y ? 5'h00 : yoc_ff)
                | {y_overcurrent, thermal_shutdown_flag}; // RULE_02 RULE_11
    end

    // Writes deliberately ignored: wr_strobe, wr_data unused in state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            xoc_ff <= 4'h0; // RULE_08
            yoc_ff <= 5'h00; // RULE_08
        end else begin
            xoc_ff <= nxt_xoc; // RULE_01 RULE_09
            yoc_ff <= nxt_yoc; // RULE_02 RULE_09
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path
    logic [6:0] sel_data;
    logic [7:0] par_word;

    always_comb begin
        unique case (rd_addr)
            SDSB_ADDR_SUPPLY: sel_data = supply_ff;
            SDSB_ADDR_XOC:    sel_data = {xoc_ff, 3'b000}; // RULE_01
            SDSB_ADDR_YOC:    sel_data = {yoc_ff, 2'b00}; // RULE_02
            SDSB_ADDR_POS:    sel_data = pos_ff; // RULE_03
            default:          sel_data = 7'h00;
        endcase
    end

    sdsb_parity u_parity (
        .data_in  (sel_data),
        .word_out (par_word)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_ff  <= SDSB_RESET_VAL;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= rd_strobe;
            if (rd_strobe) begin
                rd_data_ff <= par_word; // RULE_10
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    property p_even_parity;
        @(posedge clk) disable iff (!rst_b)
        rd_valid_ff |-> !(^rd_data_ff);
    endproperty
    a_even_parity: assert property (p_even_parity) // RULE_10
        else $error("read word parity odd");

    property p_x_hold;
        @(posedge clk) disable iff (!rst_b)
        (xoc_ff[3] && !rd_x) |=> xoc_ff[3];
    endproperty
    a_x_hold: assert property (p_x_hold) // RULE_11
        else $error("latched X flag dropped without read");

    property p_y_set;
        @(posedge clk) disable iff (!rst_b)
        thermal_shutdown_flag |=> yoc_ff[0];
    endproperty
    a_y_set: assert property (p_y_set) // RULE_02
        else $error("shutdown not latched");

    property p_x_read;
        @(posedge clk) disable iff (!rst_b)
        (rd_x && x_overcurrent == 4'h0) |=> (xoc_ff == 4'h0) && rd_valid_ff;
    endproperty
    a_x_read: assert property (p_x_read) // RULE_01
        else $error("X flags not cleared by read");

    property p_pos_live;
        @(posedge clk) disable iff (!rst_b)
        (rd_strobe && rd_addr == SDSB_ADDR_POS)
            |=> rd_data_ff[6:0] == $past(pos_ff);
    endproperty
    a_pos_live: assert property (p_pos_live) // RULE_03
        else $error("position read mismatch");

    property p_cp_live;
        @(posedge clk) disable iff (!rst_b)
        !charge_pump_low |=> !supply_ff[SDSB_PUMP_POS];
    endproperty
    a_cp_live: assert property (p_cp_live) // RULE_05
        else $error("charge pump flag stuck");

    property p_open_live;
        @(posedge clk) disable iff (!rst_b)
        open_coil_x_flag ##1 !open_coil_x_flag
            |=> !supply_ff[SDSB_OPEN_X_POS];
    endproperty
    a_open_live: assert property (p_open_live) // RULE_06
        else $error("open coil X latched");

    property p_write_ignored;
        @(posedge clk) disable iff (!rst_b)
        (wr_strobe && !rd_strobe) |=> xoc_ff == ($past(xoc_ff)
            | $past(x_overcurrent));
    endproperty
    a_write_ignored: assert property (p_write_ignored) // RULE_09
        else $error("write altered status");

    property p_y_hold;
        @(posedge clk) disable iff (!rst_b)
        (yoc_ff[0] && !rd_y) |=> yoc_ff[0];
    endproperty
    a_y_hold: assert property (p_y_hold) // RULE_11
        else $error("latched shutdown dropped without read");

    // Set must win even in a read-clear cycle
    property p_x_set;
        @(posedge clk) disable iff (!rst_b)
        (x_overcurrent != 4'h0)
            |=> (xoc_ff & $past(x_overcurrent)) == $past(x_overcurrent);
    endproperty
    a_x_set: assert property (p_x_set) // RULE_07
        else $error("X overcurrent not latched");

    property p_y_read;
        @(posedge clk) disable iff (!rst_b)
        (rd_y && y_overcurrent == 4'h0 && !thermal_shutdown_flag)
            |=> (yoc_ff == 5'h00) && rd_valid_ff;
    endproperty
    a_y_read: assert property (p_y_read) // RULE_02
        else $error("Y flags not cleared by read");

    property p_warn_live;
        @(posedge clk) disable iff (!rst_b)
        1'b1 |=> supply_ff[SDSB_WARN_POS] == $past(thermal_warning_flag);
    endproperty
    a_warn_live: assert property (p_warn_live) // RULE_04
        else $error("thermal warning not live");

    property p_open_y_live;
        @(posedge clk) disable iff (!rst_b)
        1'b1 |=> supply_ff[SDSB_OPEN_Y_POS] == $past(open_coil_y_flag);
    endproperty
    a_open_y_live: assert property (p_open_y_live) // RULE_06
        else $error("open coil Y not live");

    property p_pos_follow;
        @(posedge clk) disable iff (!rst_b)
        1'b1 |=> pos_ff == $past(translator_step_position[6:0]);
    endproperty
    a_pos_follow: assert property (p_pos_follow) // RULE_03
        else $error("position snapshot lags");

    // Only a read may change the word the host sees
    property p_data_stands;
        @(posedge clk) disable iff (!rst_b)
        !rd_strobe |=> $stable(rd_data_ff);
    endproperty
    a_data_stands: assert property (p_data_stands) // RULE_09
        else $error("read word changed without a read");

endmodule : sdsb_status_bank
`default_nettype wire

/* tb/sdsb_host_model.sv */
// Host side model: issues single status reads, one at a time.
// Assumes the bank answers one cycle after the taking edge.
`timescale 1ns/1ps
`default_nettype none
module sdsb_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] rd_data_ff,
    input  wire logic       rd_valid_ff,
    output logic            rd_strobe,
    output logic      [6:0] rd_addr
);
    initial begin
        rd_strobe = 1'b0;
        rd_addr   = 7'h00;
    end
    // No write path: nothing here relies on writes
    task automatic read(input logic [6:0] a, output logic [8:0] d);
        rd_strobe <= 1'b1;
        rd_addr   <= a;
        @(posedge clk);
        rd_strobe <= 1'b0;
        rd_addr   <= ~a; // Stale address would hide decode slips
        @(posedge clk);
        d = {rd_valid_ff, rd_data_ff};
    endtask : read
endmodule : sdsb_host_model
`default_nettype wire

/* tb/sdsb_status_bank_bench.sv */
// Bench for the status bank; reads go through the host model.
// Assumes one clock domain and fault inputs driven by the bench.
`timescale 1ns/1ps
`default_nettype none
module sdsb_status_bank_bench;
    import sdsb_pkg::*;
    logic       clk, rst_b, wr_strobe, warn, pump_low, open_x, open_y;
    logic       shutdown;
    logic       rd_strobe, rd_valid_ff;
    logic [7:0] wr_data, rd_data_ff;
    logic [3:0] xo, yo;
    logic [6:0] pos, rd_addr;
    int         n_errors = 0;
    int         total_checks = 0;
    int         cyc = 0;

    sdsb_status_bank i_sdsb_status_bank (.clk(clk), .rst_b(rst_b),
        .rd_strobe(rd_strobe), .rd_addr(rd_addr), .wr_strobe(wr_strobe),
        .wr_data(wr_data), .thermal_warning_flag(warn),
        .charge_pump_low(pump_low), .open_coil_x_flag(open_x),
        .open_coil_y_flag(open_y), .x_overcurrent(xo),
        .y_overcurrent(yo), .thermal_shutdown_flag(shutdown),
        .translator_step_position(pos), .rd_data_ff(rd_data_ff),
        .rd_valid_ff(rd_valid_ff));
    sdsb_host_model i_sdsb_host_model (.clk(clk), .rd_data_ff(rd_data_ff),
        .rd_valid_ff(rd_valid_ff), .rd_strobe(rd_strobe), .rd_addr(rd_addr));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] even_word(input logic [6:0] v);
        return {^v, v};
    endfunction : even_word
    task automatic stop_test;
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        logic [8:0] d;
        i_sdsb_host_model.read(a, d);
        total_checks++;
        if (d !== {1'b1, e}) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, d, {1'b1, e});
        end
    endtask : rd

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Ceiling well above the roughly 110 cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic t_live;
        warn <= 1'b1;
        pump_low <= 1'b1;
        open_x <= 1'b1;
        tick(3);
        rd(SDSB_ADDR_SUPPLY, even_word(7'h68));
        warn <= 1'b0;
        pump_low <= 1'b0;
        open_x <= 1'b0;
        open_y <= 1'b1;
        tick(3);
        rd(SDSB_ADDR_SUPPLY, even_word(7'h04));
        open_y <= 1'b0;
        tick(3);
        rd(SDSB_ADDR_SUPPLY, 8'h00);
    endtask : t_live
    task automatic t_latch;
        for (int i = 0; i < 4; i++) begin
            xo <= 4'h1 << i;
            yo <= 4'h8 >> i;
            shutdown <= i[0];
            tick(1);
            xo <= 4'h0;
            yo <= 4'h0;
            shutdown <= 1'b0;
            tick(3);
            rd(SDSB_ADDR_XOC, even_word({4'h1 << i, 3'h0}));
            rd(SDSB_ADDR_YOC, even_word({4'h8 >> i, i[0], 2'h0}));
            rd(SDSB_ADDR_XOC, 8'h00);
            rd(SDSB_ADDR_YOC, 8'h00);
        end
    endtask : t_latch
    // Fault still present in the clear cycle must survive the read
    task automatic t_set_wins;
        xo <= 4'h2;
        tick(1);
        rd(SDSB_ADDR_XOC, even_word(7'h10));
        xo <= 4'h0;
        rd(SDSB_ADDR_XOC, even_word(7'h10));
        rd(SDSB_ADDR_XOC, 8'h00);
    endtask : t_set_wins
    task automatic t_pos;
        pos <= 7'h55;
        tick(3);
        rd(SDSB_ADDR_POS, even_word(7'h55));
        xo <= 4'h8;
        tick(1);
        xo <= 4'h0;
        wr_strobe <= 1'b1;
        wr_data <= 8'hff;
        tick(1);
        wr_strobe <= 1'b0;
        wr_data <= 8'h00;
        tick(1);
        rd(SDSB_ADDR_POS, even_word(7'h55));
        rd(SDSB_ADDR_XOC, even_word(7'h40));
        pos <= 7'h7f;
        tick(3);
        rd(SDSB_ADDR_POS, even_word(7'h7f));
    endtask : t_pos
    // Mid-run reset must drop latched flags that no read has cleared
    task automatic t_reset;
        xo <= 4'hf;
        yo <= 4'hf;
        shutdown <= 1'b1;
        tick(1);
        xo <= 4'h0;
        yo <= 4'h0;
        shutdown <= 1'b0;
        rst_b <= 1'b0;
        tick(3);
        rst_b <= 1'b1;
        tick(1);
        rd(SDSB_ADDR_XOC, 8'h00);
        rd(SDSB_ADDR_YOC, 8'h00);
    endtask : t_reset

    initial begin
        rst_b = 1'b0;
        wr_strobe = 1'b0;
        wr_data = 8'h00;
        warn = 1'b0;
        pump_low = 1'b0;
        open_x = 1'b0;
        open_y = 1'b0;
        shutdown = 1'b0;
        xo = 4'h0;
        yo = 4'h0;
        pos = 7'h00;
        tick(3);
        rst_b <= 1'b1;
        tick(1);
        for (int a = 4; a < 9; a++) begin
            rd(a[6:0], SDSB_RESET_VAL);
        end
        t_live();
        t_latch();
        t_set_wins();
        t_pos();
        t_reset();
        stop_test();
    end
endmodule : sdsb_status_bank_bench
`default_nettype wire
